/* File: core/uhc_defines.vh */
// How it works
// - six channels: control only, bulk only, and four bulk/interrupt/isochronous ones.
// - each channel splits its request into transactions on its own.
// - request finished raises the interrupt output.
// - settings may be reloaded between requests so one channel serves many endpoints.
// - at most four interrupt or isochronous transfers configured at once.
// - general channels serve four endpoints, more through time sharing.
// - each channel holds high, full or low speed selection.
// - toggle field loads start value and reads back live toggle.
// - control channel issues setup, in or out; general ones only in or out.
// - channels b to e hold bulk, interrupt or isochronous transfer kind.
// - general channels accept packet lengths from 1 to 1024 bytes.
// - each channel holds target function address and endpoint index.
// - each channel holds split hub address and hub port.
// - each channel holds the request byte count.
// - channels b to e hold a token issue period.
// - firmware gives each channel one of six areas with start and end pointers.
// - a per-channel link bit joins a channel to an area.
// - control channel holds eight setup bytes sent as setup payload.
// - scheduler picks one executing channel, runs one transaction, moves on.
// - each channel reports done, acked, error, changed flags and a detail code.
`ifndef UHC_DEFINES_VH
`define UHC_DEFINES_VH
`define UHC_NCH 6
`define UHC_NAREA 6
`define UHC_KIND_SETUP 2'h0
`define UHC_KIND_IN 2'h1
`define UHC_KIND_OUT 2'h2
`define UHC_XFER_BULK 2'h0
`define UHC_XFER_INTR 2'h1
`define UHC_XFER_ISOC 2'h2
`define UHC_SPD_HS 2'h0
`define UHC_SPD_FS 2'h1
`define UHC_SPD_LS 2'h2
`define UHC_MAXPKT_MAX 11'h400
`define UHC_SETUP_LEN 11'h008
`define UHC_CC_OK 4'h0
`define UHC_CC_STALL 4'h1
`define UHC_CC_BADCFG 4'h2
`define UHC_CC_SHORT 4'h3
`define UHC_PERIODIC_MAX 3'h4
`endif

/* File: core/uhc_channel_set.v */
`timescale 1ns/1ps
`include "uhc_defines.vh"
// channel 0 is control, 1 bulk only, 2..5 general (b..e)
module uhc_channel_set (
  input wire clk,
  input wire reset,
  input wire [5:0] cfg_load,
  input wire [5:0] exec_set,
  input wire [1:0] cfg_speed,
  input wire cfg_toggle,
  input wire [1:0] cfg_kind,
  input wire [1:0] cfg_xfer,
  input wire [10:0] cfg_max_packet,
  input wire [6:0] cfg_func_addr,
  input wire [3:0] cfg_ep_index,
  input wire [6:0] cfg_hub_addr,
  input wire [6:0] cfg_hub_port,
  input wire [31:0] cfg_byte_count,
  input wire [15:0] cfg_interval,
  input wire [2:0] cfg_area,
  input wire [63:0] setup_payload_bytes,
  input wire [5:0] flag_clear,
  input wire frame_tick,
  output wire txn_req,
  output reg [2:0] txn_channel_ff,
  output reg [1:0] txn_kind_ff,
  output reg [1:0] txn_speed_ff,
  output reg [6:0] txn_func_addr_ff,
  output reg [3:0] txn_ep_index_ff,
  output reg [6:0] txn_hub_addr_ff,
  output reg [6:0] txn_hub_port_ff,
  output reg [10:0] txn_length_ff,
  output reg txn_toggle_ff,
  output reg [2:0] txn_area_ff,
  output reg [63:0] txn_setup_ff,
  input wire txn_ack,
  input wire txn_nak,
  input wire txn_stall,
  input wire txn_error,
  input wire [10:0] txn_actual,
  input wire [5:0] area_room,
  output reg [5:0] transfer_execute_ff,
  output reg [5:0] toggle_ff,
  output reg [5:0] request_done_flag_ff,
  output reg [5:0] transaction_acked_flag_ff,
  output reg [5:0] transaction_error_flag_ff,
  output reg [5:0] condition_changed_flag_ff,
  output reg [23:0] result_detail_code_ff,
  output reg [35:0] area_link_ff,
  output reg cfg_reject_ff,
  output wire irq
);
  // ------------------------------------------------------------
  // channel settings
  // ------------------------------------------------------------
  reg [1:0] speed_ff [0:5];
  reg [1:0] kind_ff [0:5];
  reg [1:0] xfer_ff [0:5];
  reg [10:0] maxpkt_ff [0:5];
  reg [6:0] faddr_ff [0:5];
  reg [3:0] ep_ff [0:5];
  reg [6:0] haddr_ff [0:5];
  reg [6:0] hport_ff [0:5];
  reg [31:0] remain_ff [0:5];
  reg [15:0] interval_ff [0:5];
  reg [15:0] wait_ff [0:5];
  reg [2:0] area_ff [0:5];
  reg [63:0] setup_ff;
  reg busy_ff;
  reg [2:0] last_ff;
  // one loop index per process, so no process wakes another through it
  integer p;
  integer j;
  integer n;
  integer s;
  integer w;
  // ------------------------------------------------------------
  // periodic count and request checks
  // ------------------------------------------------------------
  reg [2:0] periodic_cnt;
  reg [2:0] load_ch;
  reg load_any;
  reg load_ok;
  reg bad_kind;
  reg bad_len;
  reg bad_xfer;
  reg bad_periodic;
  reg bad_area;
  reg bad_busy;
  // a refused load leaves every setting of the channel untouched
  always @* begin
    periodic_cnt = 3'h0;
    load_ch = 3'h0;
    load_any = 1'b0;
    for (p = 2; p < `UHC_NCH; p = p + 1) begin
      if (xfer_ff[p] != `UHC_XFER_BULK)
        periodic_cnt = periodic_cnt + 3'h1;
    end
    for (p = `UHC_NCH - 1; p >= 0; p = p - 1) begin
      if (cfg_load[p]) begin
        load_ch = p[2:0];
        load_any = 1'b1;
      end
    end
    if (load_ch == 3'h0)
      bad_kind = (cfg_kind == 2'h3);
    else
      bad_kind = (cfg_kind != `UHC_KIND_IN) && (cfg_kind != `UHC_KIND_OUT);
    bad_len = (load_ch != 3'h0) && (cfg_max_packet == 11'h000
              || cfg_max_packet > `UHC_MAXPKT_MAX);
    // the bulk only channel refuses other kinds rather than ignoring them
    bad_xfer = (load_ch == 3'h1) && (cfg_xfer != `UHC_XFER_BULK);
    if (load_ch >= 3'h2 && cfg_xfer == 2'h3)
      bad_xfer = 1'b1;
    // limit applies to the new setting replacing the old one
    bad_periodic = (load_ch >= 3'h2) && (cfg_xfer != `UHC_XFER_BULK)
                   && (xfer_ff[load_ch] == `UHC_XFER_BULK)
                   && (periodic_cnt >= `UHC_PERIODIC_MAX);
    bad_area = (cfg_area >= 3'h6);
    bad_busy = transfer_execute_ff[load_ch];
    load_ok = ~(bad_kind | bad_len | bad_xfer | bad_periodic | bad_area | bad_busy);
  end
  // ------------------------------------------------------------
  // scheduler: round robin after the last served channel
  // ------------------------------------------------------------
  reg [2:0] pick;
  reg pick_ok;
  reg [2:0] c;
  reg [3:0] sum;
  // a channel whose area has no room is passed over, not waited on
  always @* begin
    pick = 3'h0;
    pick_ok = 1'b0;
    c = 3'h0;
    sum = 4'h0;
    for (j = 1; j <= `UHC_NCH; j = j + 1) begin
      // four bits so the wrap past the last channel is not lost
      sum = {1'b0, last_ff} + {1'b0, j[2:0]};
      c = (sum >= 4'h6) ? sum[2:0] - 3'h6 : sum[2:0];
      if (!pick_ok && transfer_execute_ff[c] && area_room[c] && wait_ff[c] == 16'h0000) begin
        pick = c;
        pick_ok = 1'b1;
      end
    end
  end
  assign txn_req = busy_ff;
  assign irq = |request_done_flag_ff;
  // ------------------------------------------------------------
  // result decode
  // ------------------------------------------------------------
  reg [31:0] nxt_remain;
  reg [10:0] nxt_len;
  reg [3:0] nxt_code;
  reg [2:0] k;
  reg take_pick;
  reg res_seen;
  reg ack_ok;
  reg fail_seen;
  reg short_pkt;
  always @* begin
    k = txn_channel_ff;
    take_pick = ~busy_ff & pick_ok;
    res_seen = busy_ff & (txn_ack | txn_nak | txn_stall | txn_error);
    fail_seen = res_seen & (txn_stall | txn_error);
    ack_ok = res_seen & txn_ack & ~txn_stall & ~txn_error;
    short_pkt = (txn_actual < txn_length_ff);
    nxt_remain = remain_ff[k] - {21'h0, txn_actual};
    if ({21'h0, maxpkt_ff[pick]} < remain_ff[pick])
      nxt_len = maxpkt_ff[pick];
    else
      nxt_len = remain_ff[pick][10:0];
    if (txn_stall)
      nxt_code = `UHC_CC_STALL;
    else if (txn_error)
      nxt_code = `UHC_CC_BADCFG;
    else if (short_pkt)
      nxt_code = `UHC_CC_SHORT;
    else
      nxt_code = `UHC_CC_OK;
  end
  // ------------------------------------------------------------
  // transaction descriptor, held while the request stands
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      busy_ff <= 1'b0;
      last_ff <= 3'h5;
      txn_channel_ff <= 3'h0;
      txn_kind_ff <= 2'h0;
      txn_speed_ff <= 2'h0;
      txn_func_addr_ff <= 7'h00;
      txn_ep_index_ff <= 4'h0;
      txn_hub_addr_ff <= 7'h00;
      txn_hub_port_ff <= 7'h00;
      txn_length_ff <= 11'h000;
      txn_toggle_ff <= 1'b0;
      txn_area_ff <= 3'h0;
      txn_setup_ff <= 64'h0;
    end else if (take_pick) begin
      busy_ff <= 1'b1;
      last_ff <= pick;
      txn_channel_ff <= pick;
      txn_kind_ff <= kind_ff[pick];
      txn_speed_ff <= speed_ff[pick];
      txn_func_addr_ff <= faddr_ff[pick];
      txn_ep_index_ff <= ep_ff[pick];
      txn_hub_addr_ff <= haddr_ff[pick];
      txn_hub_port_ff <= hport_ff[pick];
      if (kind_ff[pick] == `UHC_KIND_SETUP)
        txn_length_ff <= `UHC_SETUP_LEN;
      else
        txn_length_ff <= nxt_len;
      txn_toggle_ff <= toggle_ff[pick];
      txn_area_ff <= area_ff[pick];
      txn_setup_ff <= setup_ff;
    end else if (res_seen) begin
      // one transaction per pick; the next pick waits a cycle
      busy_ff <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // channel settings load and per transaction update
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      setup_ff <= 64'h0;
      toggle_ff <= 6'h00;
      area_link_ff <= 36'h0;
      cfg_reject_ff <= 1'b0;
      for (s = 0; s < `UHC_NCH; s = s + 1) begin
        speed_ff[s] <= `UHC_SPD_HS;
        kind_ff[s] <= `UHC_KIND_IN;
        xfer_ff[s] <= `UHC_XFER_BULK;
        maxpkt_ff[s] <= `UHC_SETUP_LEN;
        faddr_ff[s] <= 7'h00;
        ep_ff[s] <= 4'h0;
        haddr_ff[s] <= 7'h00;
        hport_ff[s] <= 7'h00;
        remain_ff[s] <= 32'h0;
        interval_ff[s] <= 16'h0;
        area_ff[s] <= 3'h0;
      end
    end else begin
      cfg_reject_ff <= load_any & ~load_ok;
      if (load_any && load_ok) begin
        speed_ff[load_ch] <= cfg_speed;
        toggle_ff[load_ch] <= cfg_toggle;
        kind_ff[load_ch] <= cfg_kind;
        if (load_ch >= 3'h2)
          xfer_ff[load_ch] <= cfg_xfer;
        maxpkt_ff[load_ch] <= cfg_max_packet;
        faddr_ff[load_ch] <= cfg_func_addr;
        ep_ff[load_ch] <= cfg_ep_index;
        haddr_ff[load_ch] <= cfg_hub_addr;
        hport_ff[load_ch] <= cfg_hub_port;
        // control channel count is sixteen bits wide
        remain_ff[load_ch] <= (load_ch == 3'h0) ? {16'h0, cfg_byte_count[15:0]}
                                                : cfg_byte_count;
        if (load_ch >= 3'h2)
          interval_ff[load_ch] <= cfg_interval;
        area_ff[load_ch] <= cfg_area;
        area_link_ff[load_ch*6 +: 6] <= 6'h01 << cfg_area;
        if (load_ch == 3'h0)
          setup_ff <= setup_payload_bytes;
      end
      // a loaded channel is never the busy one, so both may fall in one cycle
      if (ack_ok) begin
        toggle_ff[k] <= ~toggle_ff[k];
        if (txn_kind_ff == `UHC_KIND_SETUP)
          kind_ff[k] <= `UHC_KIND_IN;
        else
          remain_ff[k] <= nxt_remain;
      end
    end
  end
  // ------------------------------------------------------------
  // token issue period, counted in frame ticks
  // ------------------------------------------------------------
  always @(posedge clk) begin
    for (w = 0; w < `UHC_NCH; w = w + 1) begin
      if (reset)
        wait_ff[w] <= 16'h0000;
      else if (take_pick && pick == w[2:0] && w >= 2 && xfer_ff[w] != `UHC_XFER_BULK)
        wait_ff[w] <= interval_ff[w];
      else if (frame_tick && wait_ff[w] != 16'h0000)
        wait_ff[w] <= wait_ff[w] - 16'h0001;
    end
  end
  // ------------------------------------------------------------
  // execute bits, result flags and detail codes
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      transfer_execute_ff <= 6'h00;
      request_done_flag_ff <= 6'h00;
      transaction_acked_flag_ff <= 6'h00;
      transaction_error_flag_ff <= 6'h00;
      condition_changed_flag_ff <= 6'h00;
      result_detail_code_ff <= 24'h0;
    end else begin
      for (n = 0; n < `UHC_NCH; n = n + 1) begin
        // hardware set below wins over firmware clear
        if (flag_clear[n]) begin
          request_done_flag_ff[n] <= 1'b0;
          transaction_acked_flag_ff[n] <= 1'b0;
          transaction_error_flag_ff[n] <= 1'b0;
          condition_changed_flag_ff[n] <= 1'b0;
        end
        if (exec_set[n] && !(load_any && load_ch == n[2:0]))
          transfer_execute_ff[n] <= 1'b1;
      end
      if (res_seen)
        result_detail_code_ff[k*4 +: 4] <= nxt_code;
      if (fail_seen) begin
        transaction_error_flag_ff[k] <= 1'b1;
        condition_changed_flag_ff[k] <= 1'b1;
        transfer_execute_ff[k] <= 1'b0;
      end
      if (ack_ok) begin
        transaction_acked_flag_ff[k] <= 1'b1;
        // short packet or count reached ends the request
        if (txn_kind_ff != `UHC_KIND_SETUP && (nxt_remain == 32'h0 || short_pkt)) begin
          request_done_flag_ff[k] <= 1'b1;
          transfer_execute_ff[k] <= 1'b0;
        end
      end
    end
  end
endmodule // uhc_channel_set

/* File: tb/uhc_channel_set_props.sv */
`timescale 1ns/1ps
`include "uhc_defines.vh"
// ----
// link-side checks
// ----
module uhc_channel_set_props (
  input wire clk,
  input wire reset,
  input wire [5:0] cfg_load,
  input wire txn_req,
  input wire [2:0] txn_channel_ff,
  input wire [1:0] txn_kind_ff,
  input wire [10:0] txn_length_ff,
  input wire txn_ack,
  input wire txn_nak,
  input wire txn_stall,
  input wire txn_error,
  input wire [5:0] transfer_execute_ff,
  input wire [5:0] toggle_ff,
  input wire [5:0] request_done_flag_ff,
  input wire [5:0] transaction_acked_flag_ff,
  input wire [5:0] transaction_error_flag_ff,
  input wire cfg_reject_ff,
  input wire irq
);
  reg [2:0] ch_q;
  reg [5:0] tg_q;
  wire res = txn_ack | txn_nak | txn_stall | txn_error;
  // history kept so results can be tied to the channel that was served
  always @(posedge clk) begin
    ch_q <= txn_channel_ff;
    tg_q <= toggle_ff;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_irq_done: assert property (irq == |request_done_flag_ff)
    else $error("irq differs from done flags");
  a_desc_hold: assert property (txn_req && !res |=> txn_req && $stable(txn_channel_ff)
    && $stable(txn_length_ff)) else $error("descriptor moved");
  a_one_txn: assert property (txn_req && res |=> !txn_req)
    else $error("request held after result");
  a_req_exec: assert property (txn_req |-> transfer_execute_ff[txn_channel_ff])
    else $error("request for idle channel");
  a_ack_flag: assert property (txn_req && txn_ack |=> transaction_acked_flag_ff[ch_q]
    && toggle_ff[ch_q] != tg_q[ch_q]) else $error("ack not recorded");
  a_err_stop: assert property (txn_req && txn_error |=> transaction_error_flag_ff[ch_q]
    && !transfer_execute_ff[ch_q]) else $error("error not recorded");
  a_setup_len: assert property (txn_req && txn_kind_ff == `UHC_KIND_SETUP |->
    txn_channel_ff == 3'h0 && txn_length_ff == `UHC_SETUP_LEN) else $error("bad setup");
  a_len_range: assert property (txn_req |-> txn_length_ff != 11'h000
    && txn_length_ff <= `UHC_MAXPKT_MAX) else $error("length out of range");
  a_busy_reject: assert property ($onehot(cfg_load) && (cfg_load & transfer_execute_ff)
    != 6'h00 |=> cfg_reject_ff) else $error("busy load taken");
endmodule // uhc_channel_set_props

/* File: tb/uhc_link_model.sv */
`timescale 1ns/1ps
// ----
// downstream function, one answer per transaction
// ----
module uhc_link_model (
  input wire clk,
  input wire reset,
  input wire txn_req,
  input wire [10:0] txn_length_ff,
  input wire [1:0] lmode,
  input wire [2:0] ldly,
  output reg txn_ack,
  output reg txn_nak,
  output reg txn_stall,
  output reg txn_error,
  output reg [10:0] txn_actual
);
  reg [2:0] wait_ff;
  wire answered = txn_ack | txn_nak | txn_stall | txn_error;
  initial {txn_ack, txn_nak, txn_stall, txn_error, txn_actual, wait_ff} = 18'h00000;
  // lmode: 0 ack, 1 nak, 2 stall, 3 error; count is junk outside an answer
  always @(posedge clk) begin
    {txn_ack, txn_nak, txn_stall, txn_error} <= 4'h0;
    txn_actual <= ~txn_actual;
    if (reset || !txn_req || answered) begin
      wait_ff <= ldly;
    end else if (wait_ff != 3'h0) begin
      wait_ff <= wait_ff - 3'h1;
    end else begin
      {txn_ack, txn_nak, txn_stall, txn_error} <= 4'h8 >> lmode;
      txn_actual <= txn_length_ff;
    end
  end
endmodule // uhc_link_model

/* File: tb/test_uhc_channel_set.sv */
`timescale 1ns/1ps
`include "uhc_defines.vh"
// ----
// channel set bench
// ----
module test_uhc_channel_set;
  reg clk, reset, cfg_toggle, frame_tick;
  reg [5:0] cfg_load, exec_set, flag_clear, area_room;
  reg [1:0] cfg_speed, cfg_kind, cfg_xfer, lmode;
  reg [2:0] cfg_area, ldly;
  reg [3:0] cfg_ep_index;
  reg [6:0] cfg_func_addr, cfg_hub_addr, cfg_hub_port;
  reg [10:0] cfg_max_packet;
  reg [15:0] cfg_interval;
  reg [31:0] cfg_byte_count;
  reg [63:0] setup_payload_bytes, rr;
  wire txn_req, txn_ack, txn_nak, txn_stall, txn_error, txn_toggle_ff, cfg_reject_ff, irq;
  wire [1:0] txn_kind_ff, txn_speed_ff;
  wire [2:0] txn_channel_ff, txn_area_ff;
  wire [3:0] txn_ep_index_ff;
  wire [6:0] txn_func_addr_ff, txn_hub_addr_ff, txn_hub_port_ff;
  wire [10:0] txn_length_ff, txn_actual;
  wire [63:0] txn_setup_ff;
  wire [5:0] transfer_execute_ff, toggle_ff, request_done_flag_ff, transaction_acked_flag_ff;
  wire [5:0] transaction_error_flag_ff, condition_changed_flag_ff;
  wire [23:0] result_detail_code_ff;
  wire [35:0] area_link_ff;
  integer seed = 43, bad_count = 0, n_compared = 0, cyc = 0, i, m;
  integer rem [0:5], mp [0:5], nack [0:5], tg [0:5], xk [0:5], fa [0:5];
  integer sp [0:5], gch = 0;
  reg acc = 1'b0;
  uhc_channel_set dut_u (.*);
  uhc_link_model link_u (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // free-running noise; the routing fields among it are recorded at each accepted load and checked per ack
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rr = {$random(seed), $random(seed)};
    area_room <= rr[5:0] | rr[11:6];
    {ldly, frame_tick} <= {rr[14:12], rr[17:15] == 3'h0};
    cfg_speed <= (rr[19:18] == 2'h3) ? 2'h1 : rr[19:18];
    {cfg_ep_index, cfg_hub_addr, cfg_hub_port} <= rr[37:20];
    cfg_interval <= {14'h0000, rr[39:38]};
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  task chk(input [63:0] got, input [63:0] exp, input [39:0] what);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %s exp %0h got %0h", what, exp, got);
      end
    end
  endtask
  task final_report;
    begin
      if (bad_count == 0 && n_compared > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  task go(input integer ch, input [1:0] kd, input [1:0] xf, input integer mx,
      input integer cnt, input rj);
    begin
      @(posedge clk);
      cfg_load <= 6'h01 << ch;
      gch = ch;
      acc = !rj;
      {cfg_kind, cfg_xfer, cfg_max_packet, cfg_byte_count} <= {kd, xf, mx[10:0], cnt};
      cfg_area <= 3'h5 - ch[2:0];
      if (!rj) begin
        {rem[ch], mp[ch], nack[ch], xk[ch]} = {cnt, mx, 32'h0, 30'h0, xf};
        tg[ch] = $random(seed) & 1;
        fa[ch] = $random(seed) & 127;
        cfg_toggle <= tg[ch][0];
        cfg_func_addr <= fa[ch][6:0];
      end
      @(posedge clk);
      cfg_load <= 6'h00;
      exec_set <= rj ? 6'h00 : 6'h01 << ch;
      #1 chk(cfg_reject_ff, rj, "rej");
      @(posedge clk);
      exec_set <= 6'h00;
    end
  endtask
  // waits for the channel to stop, then judges and clears its flags
  task fin(input integer ch, input integer md);
    begin
      @(posedge clk);
      while (transfer_execute_ff[ch] === 1'b1) @(posedge clk);
      #1;
      if (md == 0) begin
        chk(request_done_flag_ff[ch], 1, "done");
        chk(irq, 1, "irq");
        if (ch != 0) chk(rem[ch], 0, "rem");
        if (xk[ch] != 2) chk(toggle_ff[ch], (tg[ch] ^ nack[ch]) & 1, "tgl");
      end else begin
        chk(result_detail_code_ff[ch*4 +: 4], md == 3 ? 2 : 1, "code");
        chk(condition_changed_flag_ff[ch], 1, "chg");
      end
      chk(area_link_ff[ch*6 +: 6], 6'h20 >> ch, "area");
      flag_clear <= 6'h01 << ch;
      @(posedge clk);
      flag_clear <= 6'h00;
      #1 chk({request_done_flag_ff[ch], transaction_error_flag_ff[ch], transaction_acked_flag_ff[ch],
          condition_changed_flag_ff[ch], irq}, 0, "clr");
    end
  endtask
  always @(posedge clk) begin
    if (!reset && cfg_load != 6'h00 && acc)
      sp[gch] = {cfg_speed, cfg_ep_index, cfg_hub_addr, cfg_hub_port};
    if (!reset && txn_req === 1'b1 && txn_ack === 1'b1) begin
      chk(txn_toggle_ff, (tg[txn_channel_ff] ^ nack[txn_channel_ff]) & 1, "ttgl");
      nack[txn_channel_ff] = nack[txn_channel_ff] + 1;
      chk({txn_speed_ff, txn_ep_index_ff, txn_hub_addr_ff, txn_hub_port_ff},
          sp[txn_channel_ff], "route");
      chk(txn_area_ff, 5 - txn_channel_ff, "tarea");
      chk(txn_func_addr_ff, fa[txn_channel_ff], "fa");
      if (txn_kind_ff == `UHC_KIND_SETUP) begin
        chk(txn_setup_ff, setup_payload_bytes, "setup");
      end else if (txn_channel_ff != 3'h0) begin
        m = rem[txn_channel_ff] < mp[txn_channel_ff] ? rem[txn_channel_ff] : mp[txn_channel_ff];
        chk(txn_length_ff, m, "len");
        rem[txn_channel_ff] = rem[txn_channel_ff] - txn_length_ff;
      end
    end
  end
  initial begin
    reset = 1'b1;
    {cfg_load, exec_set, flag_clear, area_room, lmode, ldly, frame_tick, cfg_toggle} = 0;
    {cfg_speed, cfg_kind, cfg_xfer, cfg_area, cfg_ep_index, cfg_func_addr} = 0;
    {cfg_hub_addr, cfg_hub_port, cfg_max_packet, cfg_interval, cfg_byte_count} = 0;
    setup_payload_bytes = {$random(seed), $random(seed)};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    go(0, `UHC_KIND_SETUP, `UHC_XFER_BULK, 8, 8, 0);
    fin(0, 0);
    // reloads serve new endpoints; 1 and 1024 byte packets come first
    for (i = 0; i < 15; i = i + 1) begin
      m = (i == 0) ? 1024 : (i == 1) ? 1 : 1 + $unsigned($random(seed)) % 1024;
      go(1 + i % 5, 1 + i % 2, (i % 5) ? i % 3 : 0, m, 1 + $unsigned($random(seed)) % (3 * m), 0);
      fin(1 + i % 5, 0);
    end
    go(2, `UHC_KIND_SETUP, `UHC_XFER_BULK, 64, 8, 1);
    go(1, `UHC_KIND_IN, `UHC_XFER_INTR, 64, 8, 1);
    go(3, `UHC_KIND_IN, `UHC_XFER_BULK, 0, 8, 1);
    go(4, `UHC_KIND_OUT, `UHC_XFER_BULK, 1025, 8, 1);
    go(5, `UHC_KIND_IN, 2'h3, 64, 8, 1);
    lmode <= 2'h1;
    go(1, `UHC_KIND_IN, `UHC_XFER_BULK, 64, 200, 0);
    repeat (30) @(posedge clk);
    go(1, `UHC_KIND_OUT, `UHC_XFER_BULK, 64, 8, 1);
    chk({transfer_execute_ff[1], nack[1]}, 33'h100000000, "nak");
    lmode <= 2'h0;
    fin(1, 0);
    for (i = 2; i < 4; i = i + 1) begin
      lmode <= i;
      go(i + 1, `UHC_KIND_OUT, `UHC_XFER_BULK, 64, 500, 0);
      fin(i + 1, i);
    end
    final_report;
  end
endmodule // test_uhc_channel_set
bind uhc_channel_set uhc_channel_set_props props_u (.*);
